// ===== hw/t0ap_defs.svh
// Constants for the terminal-side T=0 command transport controller.
// Assumes a byte link to the card that is already framed and error-checked.
`ifndef T0AP_DEFS_SVH
`define T0AP_DEFS_SVH
`define T0AP_HDR_LAST 3'h4
`define T0AP_INS_GETRESP 8'hC0
`define T0AP_PB_NULL 8'h60
`define T0AP_SW1_MORE 8'h61
`define T0AP_SW1_WRONGLE 8'h6C
`define T0AP_SW1_WARN0 8'h62
`define T0AP_SW1_WARN1 8'h63
`define T0AP_SW1_OK 8'h90
`define T0AP_SW2_OK 8'h00
`define T0AP_NIB_PROC 4'h6
`define T0AP_NIB_APP 4'h9
`define T0AP_LEN_ZERO 8'h00
`define T0AP_LEN_MAX 9'h100
`endif

// ===== hw/t0ap_pkg.sv
// Types shared by the T=0 transport controller.
// Assumes t0ap_defs.svh is included by the design file for the numbers.
package t0ap_pkg;
	typedef enum logic [1:0] {
		T0AP_C1 = 2'b00,
		T0AP_C2 = 2'b01,
		T0AP_C3 = 2'b10,
		T0AP_C4 = 2'b11
	} t0ap_case_t;
	typedef enum logic [2:0] {
		T0AP_IDLE = 3'b000,
		T0AP_HDR = 3'b001,
		T0AP_PROC = 3'b010,
		T0AP_TXD = 3'b011,
		T0AP_RXD = 3'b100,
		T0AP_SW2 = 3'b101
	} t0ap_state_t;
	typedef struct packed {
		logic [7:0] cla; // Class byte
		logic [7:0] ins; // Instruction byte
		logic [7:0] p1; // Parameter 1
		logic [7:0] p2; // Parameter 2
		logic [7:0] p3; // Length byte
	} t0ap_hdr_t;
	typedef struct packed {
		t0ap_case_t kase; // Command case
		logic [7:0] cla; // Class byte
		logic [7:0] ins; // Instruction byte
		logic [7:0] p1; // Parameter 1
		logic [7:0] p2; // Parameter 2
		logic [7:0] lc; // Command data length
		logic [7:0] le; // Expected length, zero means 256
	} t0ap_req_t;
	typedef struct packed {
		logic [7:0] sw1; // First status byte
		logic [7:0] sw2; // Second status byte
	} t0ap_sw_t;
endpackage : t0ap_pkg

// ===== hw/t0ap_transport.sv
// Terminal transport layer for T=0: header, data, status and data retrieval.
// Assumes byte links on mclk; card bytes arrive already framed, one per pulse.
`timescale 1ns/1ps
`include "t0ap_defs.svh"
module t0ap_transport (
	input wire logic mclk, // 40 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic req_valid, // Command offered
	output logic req_ready, // Command taken when idle
	input wire t0ap_pkg::t0ap_req_t req, // Command fields
	input wire logic [7:0] cmd_data, // Command data byte
	input wire logic cmd_data_valid, // Command data byte offered
	output logic cmd_data_ready, // Command data byte taken
	output logic [7:0] rsp_data, // Response body byte
	output logic rsp_data_valid, // Response byte pulse
	output t0ap_pkg::t0ap_sw_t rsp_sw, // Final status
	output logic rsp_done, // Command finished pulse
	output logic rsp_err, // Bad command length with done
	output logic [7:0] tx_byte, // Byte to card
	output logic tx_valid, // Byte to card held
	input wire logic tx_ready, // Card link accepts byte
	input wire logic [7:0] rx_byte, // Byte from card
	input wire logic rx_valid // Byte from card pulse
);
	t0ap_pkg::t0ap_state_t state, next_state; // Sequencer state
	t0ap_pkg::t0ap_hdr_t hdr, next_hdr; // Header in flight, kept for resend
	t0ap_pkg::t0ap_case_t kase, next_kase; // Case of the header in flight
	logic [2:0] idx, next_idx; // Header byte index
	logic [7:0] send_left, next_send_left; // Command bytes still to send
	logic [8:0] rx_left, next_rx_left; // Response bytes still expected
	logic burst, next_burst; // Send all remaining bytes
	logic single, next_single; // One byte only under inverted INS
	logic data_done, next_data_done; // Case 3 or 4 data fully sent
	logic [7:0] sw1, next_sw1; // First status byte seen
	logic [7:0] next_tx_byte; // Next byte to card
	logic next_tx_valid; // Next byte valid
	logic [7:0] next_rsp_data; // Next response byte
	logic next_rsp_data_valid; // Next response pulse
	t0ap_pkg::t0ap_sw_t next_rsp_sw; // Next status
	logic next_rsp_done; // Next done pulse
	logic next_rsp_err; // Next error flag
	logic tx_take; // Card link took a byte
	logic bad_len; // Case 3/4 with zero length
	logic retrieve; // Case 4 status that still owes data

	// Header byte picker, used while sending the header
	function automatic logic [7:0] hdr_byte(input t0ap_pkg::t0ap_hdr_t h, input logic [2:0] i);
		case (i)
			3'h0: hdr_byte = h.cla;
			3'h1: hdr_byte = h.ins;
			3'h2: hdr_byte = h.p1;
			3'h3: hdr_byte = h.p2;
			default: hdr_byte = h.p3;
		endcase
	endfunction : hdr_byte

	// Zero length byte stands for 256
	function automatic logic [8:0] len_of(input logic [7:0] b);
		len_of = (b == `T0AP_LEN_ZERO) ? `T0AP_LEN_MAX : {1'b0, b};
	endfunction : len_of

	assign tx_take = tx_valid && tx_ready;
	assign req_ready = (state == t0ap_pkg::T0AP_IDLE);
	assign bad_len = (req.kase == t0ap_pkg::T0AP_C3 || req.kase == t0ap_pkg::T0AP_C4)
		&& req.lc == `T0AP_LEN_ZERO;
	// Data is pulled only when the link slot is free, so one byte is in flight
	assign cmd_data_ready = (state == t0ap_pkg::T0AP_TXD) && !tx_valid && send_left != 8'h00;
	// Warning or application status other than 9000 after case 4 data still owes response data
	assign retrieve = kase == t0ap_pkg::T0AP_C4 && data_done
		&& (sw1 == `T0AP_SW1_WARN0 || sw1 == `T0AP_SW1_WARN1
		|| (sw1[7:4] == `T0AP_NIB_APP && !(sw1 == `T0AP_SW1_OK && rx_byte == `T0AP_SW2_OK)));

	// Next-state logic for the whole exchange
	always_comb begin
		next_state = state;
		next_hdr = hdr;
		next_kase = kase;
		next_idx = idx;
		next_send_left = send_left;
		next_rx_left = rx_left;
		next_burst = burst;
		next_single = single;
		next_data_done = data_done;
		next_sw1 = sw1;
		next_tx_byte = tx_byte;
		next_tx_valid = tx_valid && !tx_ready;
		next_rsp_data = rsp_data;
		next_rsp_data_valid = 1'b0;
		next_rsp_sw = rsp_sw;
		next_rsp_done = 1'b0;
		next_rsp_err = rsp_err;
		case (state)
			t0ap_pkg::T0AP_IDLE: begin
				if (req_valid) begin // New command
					next_rsp_err = 1'b0;
					next_kase = req.kase;
					next_hdr = {req.cla, req.ins, req.p1, req.p2, `T0AP_LEN_ZERO};
					next_send_left = 8'h00;
					next_rx_left = 9'h000;
					next_data_done = 1'b0;
					next_idx = 3'h0;
					if (bad_len) begin // Refused, nothing reaches the card
						next_rsp_err = 1'b1;
						next_rsp_done = 1'b1;
					end else begin
						next_state = t0ap_pkg::T0AP_HDR;
						if (req.kase == t0ap_pkg::T0AP_C2) begin // Le carried as is
							next_hdr.p3 = req.le;
							next_rx_left = len_of(req.le);
						end else if (req.kase != t0ap_pkg::T0AP_C1) begin
							next_hdr.p3 = req.lc;
							next_send_left = req.lc;
						end
					end
				end
			end
			t0ap_pkg::T0AP_HDR: begin
				if (!tx_valid) begin // Load next header byte
					next_tx_byte = hdr_byte(hdr, idx);
					next_tx_valid = 1'b1;
				end else if (tx_ready) begin
					next_idx = idx + 3'h1;
					if (idx == `T0AP_HDR_LAST) begin // Header out, await card
						next_idx = 3'h0;
						next_state = t0ap_pkg::T0AP_PROC;
					end
				end
			end
			t0ap_pkg::T0AP_PROC: begin
				if (rx_valid) begin
					if (rx_byte == `T0AP_PB_NULL) begin // Card asks for patience
						next_state = t0ap_pkg::T0AP_PROC;
					end else if (rx_byte == hdr.ins || rx_byte == ~hdr.ins) begin
						next_burst = (rx_byte == hdr.ins);
						next_single = (rx_byte != hdr.ins);
						if (send_left != 8'h00) begin
							next_state = t0ap_pkg::T0AP_TXD;
						end else if (rx_left != 9'h000) begin
							next_state = t0ap_pkg::T0AP_RXD;
						end
					end else if (rx_byte[7:4] == `T0AP_NIB_PROC
						|| rx_byte[7:4] == `T0AP_NIB_APP) begin // Status ends data phase
						next_sw1 = rx_byte;
						next_state = t0ap_pkg::T0AP_SW2;
					end
				end
			end
			t0ap_pkg::T0AP_TXD: begin
				if (cmd_data_ready && cmd_data_valid) begin // Take one command byte
					next_tx_byte = cmd_data;
					next_tx_valid = 1'b1;
				end else if (tx_take) begin
					next_send_left = send_left - 8'h01;
					if (send_left == 8'h01) begin
						next_data_done = 1'b1;
					end
					if (!burst || send_left == 8'h01) begin
						next_state = t0ap_pkg::T0AP_PROC;
					end
				end
			end
			t0ap_pkg::T0AP_RXD: begin
				if (rx_valid) begin // Body byte to the application
					next_rsp_data = rx_byte;
					next_rsp_data_valid = 1'b1;
					next_rx_left = rx_left - 9'h001;
					if (single || rx_left == 9'h001) begin
						next_state = t0ap_pkg::T0AP_PROC;
					end
				end
			end
			t0ap_pkg::T0AP_SW2: begin
				if (rx_valid) begin
					next_state = t0ap_pkg::T0AP_HDR;
					next_send_left = 8'h00;
					if (sw1 == `T0AP_SW1_MORE) begin // Fetch the rest, swallowed here
						next_hdr = {hdr.cla, `T0AP_INS_GETRESP, 8'h00, 8'h00, rx_byte};
						next_rx_left = len_of(rx_byte);
						next_kase = t0ap_pkg::T0AP_C2;
					end else if (sw1 == `T0AP_SW1_WRONGLE) begin // Same header, new length
						next_hdr.p3 = rx_byte;
						next_rx_left = len_of(rx_byte);
					end else if (retrieve) begin // Data still owed after case 4
						next_hdr = {hdr.cla, `T0AP_INS_GETRESP, 8'h00, 8'h00, `T0AP_LEN_ZERO};
						next_rx_left = `T0AP_LEN_MAX;
						next_kase = t0ap_pkg::T0AP_C2;
					end else begin // Final status goes up unchanged
						next_rsp_sw = {sw1, rx_byte};
						next_rsp_done = 1'b1;
						next_state = t0ap_pkg::T0AP_IDLE;
					end
				end
			end
			default: next_state = t0ap_pkg::T0AP_IDLE;
		endcase
	end

	// State and output registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= t0ap_pkg::T0AP_IDLE;
			hdr <= '0;
			kase <= t0ap_pkg::T0AP_C1;
			idx <= 3'h0;
			send_left <= 8'h00;
			rx_left <= 9'h000;
			burst <= 1'b0;
			single <= 1'b0;
			data_done <= 1'b0;
			sw1 <= 8'h00;
			tx_byte <= 8'h00;
			tx_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_data_valid <= 1'b0;
			rsp_sw <= '0;
			rsp_done <= 1'b0;
			rsp_err <= 1'b0;
		end else begin
			state <= next_state;
			hdr <= next_hdr;
			kase <= next_kase;
			idx <= next_idx;
			send_left <= next_send_left;
			rx_left <= next_rx_left;
			burst <= next_burst;
			single <= next_single;
			data_done <= next_data_done;
			sw1 <= next_sw1;
			tx_byte <= next_tx_byte;
			tx_valid <= next_tx_valid;
			rsp_data <= next_rsp_data;
			rsp_data_valid <= next_rsp_data_valid;
			rsp_sw <= next_rsp_sw;
			rsp_done <= next_rsp_done;
			rsp_err <= next_rsp_err;
		end
	end

	// Checks on the sequencer
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence req_taken_s;
		req_valid && req_ready && !bad_len;
	endsequence
	sequence sw2_in_s;
		state == t0ap_pkg::T0AP_SW2 && rx_valid;
	endsequence
	hdr_first_a: assert property (req_taken_s |=> state == t0ap_pkg::T0AP_HDR ##1
		(tx_valid && tx_byte == $past(req.cla, 2))) else $error("header not sent first");
	len_refuse_a: assert property (req_valid && req_ready && bad_len |=>
		rsp_err && rsp_done && state == t0ap_pkg::T0AP_IDLE) else $error("bad length taken");
	c4_p3_a: assert property (req_taken_s and req.kase == t0ap_pkg::T0AP_C4 |=>
		hdr.p3 == $past(req.lc)) else $error("case 4 P3 not Lc");
	getresp_a: assert property (sw2_in_s and sw1 == `T0AP_SW1_MORE |=>
		state == t0ap_pkg::T0AP_HDR && hdr.ins == `T0AP_INS_GETRESP
		&& hdr.p3 == $past(rx_byte) && kase == t0ap_pkg::T0AP_C2) else $error("61 not handled");
	resend_a: assert property (sw2_in_s and sw1 == `T0AP_SW1_WRONGLE |=>
		hdr.p3 == $past(rx_byte) && hdr.ins == $past(hdr.ins)) else $error("6C not resent");
	warn_fetch_a: assert property (sw2_in_s and retrieve and sw1 != `T0AP_SW1_MORE
		|=> hdr.p3 == `T0AP_LEN_ZERO && hdr.ins == `T0AP_INS_GETRESP) else $error("no fetch");
	no_pb_up_a: assert property (rsp_done |-> rsp_sw.sw1 != `T0AP_SW1_MORE
		&& rsp_sw.sw1 != `T0AP_SW1_WRONGLE) else $error("procedure bytes passed up");
	status_end_a: assert property (sw2_in_s and !retrieve and sw1[7:4] == `T0AP_NIB_APP
		|=> rsp_done && state == t0ap_pkg::T0AP_IDLE ##1 !rsp_done) else $error("no end");
	body_byte_a: assert property (state == t0ap_pkg::T0AP_RXD && rx_valid |=>
		rsp_data_valid && rsp_data == $past(rx_byte)) else $error("body byte lost");
endmodule : t0ap_transport

// ===== tb/t0ap_card.sv
// Behavioural card that answers T=0 headers, data and GET RESPONSE.
// Assumes the terminal holds tx_valid until tx_ready; card bytes go out as pulses.
`timescale 1ns/1ps
`include "t0ap_defs.svh"
module t0ap_card (
	input wire logic mclk, // Shared clock
	input wire logic tx_valid, // Terminal byte offered
	input wire logic [7:0] tx_byte, // Terminal byte
	output logic tx_ready, // Card accepts byte
	output logic [7:0] rx_byte, // Card byte
	output logic rx_valid, // Card byte pulse
	input wire logic has_data, // Command carries data
	input wire logic slow, // Accept on alternate cycles
	input wire logic [8:0] avail, // Response bytes held
	input wire logic [15:0] err_sw // Nonzero: answer this status, except to GET RESPONSE
);
	logic [7:0] h [5]; // Received header
	logic [7:0] d; // Scratch data byte
	logic ph = 1'b0; // Slow accept phase
	int n; // Requested length
	int left = 0; // Response bytes not yet returned
	int sent = 0; // Response bytes returned so far, keeps the pattern running
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'hFF;
	end
	// Ready toggles in slow mode to stretch every terminal byte transfer
	always @(posedge mclk) ph <= ~ph;
	assign tx_ready = slow ? ph : 1'b1;
	task automatic get(output logic [7:0] b);
		do @(posedge mclk); while (!(tx_valid && tx_ready));
		b = tx_byte;
	endtask : get
	// Idle level is the inverse of the last byte, never a stale copy
	task automatic put(input logic [7:0] b);
		repeat (2) @(negedge mclk);
		rx_byte = b;
		rx_valid = 1'b1;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask : put
	// One command per pass
	always begin
		for (int i = 0; i < 5; i++) get(h[i]);
		if (h[1] != `T0AP_INS_GETRESP) begin // Fresh command refills the response store
			left = int'(avail);
			sent = 0;
		end
		if (has_data && h[1] != `T0AP_INS_GETRESP) begin // Cases 3 and 4
			if (slow) begin // Null byte first, then one byte per inverted INS
				put(`T0AP_PB_NULL);
				for (int i = 0; i < h[4]; i++) begin
					put(~h[1]);
					get(d);
				end
			end else begin // INS releases all data at once
				put(h[1]);
				for (int i = 0; i < h[4]; i++) get(d);
			end
			if (err_sw != 16'h0000) begin
				put(err_sw[15:8]);
				put(err_sw[7:0]);
			end else if (avail != 9'h000) begin
				put(`T0AP_SW1_MORE);
				put(avail[7:0]);
			end else begin
				put(8'h90);
				put(8'h00);
			end
		end else begin // Cases 1 and 2, GET RESPONSE alike
			n = (h[4] == 8'h00) ? 256 : int'(h[4]);
			if (err_sw != 16'h0000 && h[1] != `T0AP_INS_GETRESP) begin
				put(err_sw[15:8]);
				put(err_sw[7:0]);
			end else if (left == 0) begin
				put(8'h90);
				put(8'h00);
			end else if (n > left) begin
				put(`T0AP_SW1_WRONGLE);
				put(8'(left));
			end else begin
				put(h[1]);
				for (int i = 0; i < n; i++) begin
					put(8'(8'hA0 + sent));
					sent++;
				end
				left -= n;
				if (left != 0) begin // Short request: name the remainder
					put(`T0AP_SW1_MORE);
					put(8'(left));
				end else begin
					put(8'h90);
					put(8'h00);
				end
			end
		end
	end
endmodule : t0ap_card

// ===== tb/tb_top.sv
// Self-checking bench: each command scenario runs one command through controller and card, plus a reset test.
// Assumes the design in hw/ and the card model in tb/t0ap_card.sv.
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0, reset_n = 1'b0; // Clock and reset
	logic req_valid = 1'b0, req_ready; // Command handshake
	t0ap_pkg::t0ap_req_t req = '0; // Command fields
	logic [7:0] cmd_data = 8'h00, tx_byte, rx_byte, rsp_data; // Byte paths
	logic cmd_data_valid = 1'b0, cmd_data_ready, rsp_data_valid, rsp_done, rsp_err;
	logic tx_valid, tx_ready, rx_valid; // Card link strobes
	t0ap_pkg::t0ap_sw_t rsp_sw; // Final status
	logic has = 1'b0, slow = 1'b0; // Card controls
	logic [8:0] avail = 9'h000; // Card response size
	logic [15:0] err_sw = 16'h0000; // Card error status
	logic [7:0] txq [$], bq [$], ex [$]; // Seen tx, body, expected tx
	int ci = 0, lcur = 0, cyc = 0, error_cnt = 0, checked = 0; // Counters
	logic dn = 1'b0; // Done seen
	logic [7:0] cla = 8'h80; // Class byte of the current scenario
	always #12.5 mclk = ~mclk;
	t0ap_transport DUT (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .cmd_data(cmd_data),
		.cmd_data_valid(cmd_data_valid), .cmd_data_ready(cmd_data_ready),
		.rsp_data(rsp_data), .rsp_data_valid(rsp_data_valid), .rsp_sw(rsp_sw),
		.rsp_done(rsp_done), .rsp_err(rsp_err), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
	t0ap_card card (.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .has_data(has),
		.slow(slow), .avail(avail), .err_sw(err_sw));
	// Monitor: record traffic and the hang limit
	always @(posedge mclk) begin
		if (tx_valid && tx_ready) txq.push_back(tx_byte);
		if (rsp_data_valid) bq.push_back(rsp_data);
		if (rsp_done) dn <= 1'b1;
		if (cmd_data_valid && cmd_data_ready) ci <= ci + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	// Command data source, changed off the sampling edge
	always @(negedge mclk) begin
		cmd_data_valid = (ci < lcur);
		cmd_data = 8'(8'h50 + ci);
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic hdr(input logic [7:0] ins, input logic [7:0] p, input logic [7:0] p3);
		ex.push_back(cla);
		ex.push_back(ins);
		ex.push_back(p);
		ex.push_back(p);
		ex.push_back(p3);
	endtask : hdr
	// Shared command run; status keeps the previous command's value after a refusal, so skipped there
	task automatic run(input t0ap_pkg::t0ap_case_t k, input logic [7:0] ins, input logic [7:0] lc,
		input logic [7:0] le, input logic hd, input logic sl, input logic [8:0] av,
		input logic [15:0] er, input logic [15:0] sw, input int nb, input logic bad);
		int w;
		@(negedge mclk);
		txq.delete();
		bq.delete();
		ci = 0;
		lcur = int'(lc);
		dn = 1'b0;
		has = hd;
		slow = sl;
		avail = av;
		err_sw = er;
		req = {k, cla, ins, 8'h5A, 8'h5A, lc, le};
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		w = 0;
		while (!dn && w < 3000) begin
			@(negedge mclk);
			w++;
		end
		check("done", 16'(dn), 16'h0001);
		check("tx count", 16'(txq.size()), 16'(ex.size()));
		foreach (ex[i]) check("tx byte", 16'(txq[i]), 16'(ex[i]));
		check("body count", 16'(bq.size()), 16'(nb));
		foreach (bq[i]) check("body byte", 16'(bq[i]), 16'(8'(8'hA0 + i)));
		if (!bad) check("status", rsp_sw, sw);
		check("length error", 16'(rsp_err), 16'(bad));
		ex.delete();
		$display("TB: command %h done, mismatches %0d", ins, error_cnt);
	endtask : run
	task automatic t_case1;
		hdr(8'hB1, 8'h5A, 8'h00);
		run(t0ap_pkg::T0AP_C1, 8'hB1, 0, 0, 0, 0, 0, 0, 16'h9000, 0, 0);
	endtask : t_case1
	task automatic t_case2_relen;
		hdr(8'hB2, 8'h5A, 8'h05);
		hdr(8'hB2, 8'h5A, 8'h03);
		run(t0ap_pkg::T0AP_C2, 8'hB2, 0, 8'h05, 0, 0, 3, 0, 16'h9000, 3, 0);
	endtask : t_case2_relen
	task automatic t_case2_full;
		hdr(8'hB6, 8'h5A, 8'h00);
		run(t0ap_pkg::T0AP_C2, 8'hB6, 0, 0, 0, 0, 9'h100, 0, 16'h9000, 256, 0);
	endtask : t_case2_full
	task automatic t_case2_part;
		hdr(8'hBA, 8'h5A, 8'h02);
		hdr(8'hC0, 8'h00, 8'h03);
		run(t0ap_pkg::T0AP_C2, 8'hBA, 0, 8'h02, 0, 0, 5, 0, 16'h9000, 5, 0);
	endtask : t_case2_part
	task automatic t_case2_abn;
		hdr(8'hB8, 8'h5A, 8'h04);
		run(t0ap_pkg::T0AP_C2, 8'hB8, 0, 8'h04, 0, 0, 4, 16'h6A82, 16'h6A82, 0, 0);
	endtask : t_case2_abn
	task automatic t_case3;
		hdr(8'hB3, 8'h5A, 8'h02);
		ex.push_back(8'h50);
		ex.push_back(8'h51);
		run(t0ap_pkg::T0AP_C3, 8'hB3, 2, 0, 1, 1, 0, 0, 16'h9000, 0, 0);
	endtask : t_case3
	task automatic t_case4;
		cla = 8'h00;
		hdr(8'hB4, 8'h5A, 8'h01);
		ex.push_back(8'h50);
		hdr(8'hC0, 8'h00, 8'h02);
		run(t0ap_pkg::T0AP_C4, 8'hB4, 1, 0, 1, 1, 2, 0, 16'h9000, 2, 0);
	endtask : t_case4
	task automatic t_case4_warn;
		cla = 8'hA0;
		hdr(8'hB5, 8'h5A, 8'h01);
		ex.push_back(8'h50);
		hdr(8'hC0, 8'h00, 8'h00);
		hdr(8'hC0, 8'h00, 8'h03);
		run(t0ap_pkg::T0AP_C4, 8'hB5, 1, 0, 1, 0, 3, 16'h6283, 16'h9000, 3, 0);
	endtask : t_case4_warn
	task automatic t_case4_err;
		cla = 8'h81;
		hdr(8'hB7, 8'h5A, 8'h01);
		ex.push_back(8'h50);
		run(t0ap_pkg::T0AP_C4, 8'hB7, 1, 0, 1, 0, 2, 16'h6A82, 16'h6A82, 0, 0);
	endtask : t_case4_err
	task automatic t_refuse;
		run(t0ap_pkg::T0AP_C3, 8'hB9, 0, 0, 1, 0, 0, 0, 16'h0000, 0, 1);
	endtask : t_refuse
	// Reset between commands must clear a held length error and leave the link idle
	task automatic t_reset;
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (2) @(negedge mclk);
		check("reset error flag", 16'(rsp_err), 16'h0000);
		check("reset link idle", 16'(tx_valid), 16'h0000);
		reset_n = 1'b1;
		@(negedge mclk);
		check("reset ready", 16'(req_ready), 16'h0001);
		$display("TB: reset test done, mismatches %0d", error_cnt);
	endtask : t_reset
	task automatic conclude;
		$display("TB: checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	// Main sequence after a two-cycle reset
	initial begin
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		t_case1();
		t_case2_relen();
		t_case2_full();
		t_case2_part();
		t_case2_abn();
		t_case3();
		t_case4();
		t_case4_warn();
		t_case4_err();
		t_refuse();
		t_reset();
		t_case1();
		conclude();
	end
endmodule : tb_top
